// [common/dssm_pkg.sv]
// Constants shared by the stream stuff mapper
package dssm_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int ENV_RATE_HZ = 8000;
	localparam int ENV_PERIOD_NS = 125000;
	localparam int ENV_CYC = ENV_PERIOD_NS / CLK_PERIOD_NS;
	// ****************************************
	// Envelope layout
	// ****************************************
	localparam int ROWS = 9;
	localparam int CTRL_PER_ROW = 5;
	localparam int CTRL_W = ROWS * CTRL_PER_ROW;
	localparam int CNT_W = 13;
	localparam int BL_W = 16;
	localparam int ACC_W = 14;
	localparam logic [CNT_W-1:0] FIXED_BITS = 13'h15D5;
	localparam logic [CNT_W-1:0] NOM_BITS = 13'h15D8;
	localparam logic [CNT_W-1:0] FAST_BITS = 13'h15D9;
	localparam logic [CNT_W-1:0] SLOW_BITS = 13'h15D7;
	localparam logic [3:0] NOM_OPP = 4'h3;
	localparam logic [3:0] FAST_OPP = 4'h4;
	localparam logic [3:0] SLOW_OPP = 4'h2;
	localparam logic [2:0] VOTE_MIN = 3'h3;
	localparam logic [BL_W-1:0] BL_LIMIT = 16'h0010;
	localparam int WORD_W = CNT_W + ROWS + CTRL_W;
endpackage

// [rtl/dssm_mapper.sv]
// Stuff decision mapper and control-bit demap decoder
`timescale 1ns/1ps
// How it works
// - An envelope tick fires eight thousand times per second from the clock.
// - With no offset each envelope carries 5592 data bits.
// - 5589 fixed data positions; the remainder comes from stuff opportunities.
// - Nominal envelope uses 3 of 9 opportunities for data, 6 stuff.
// - Surplus backlog gives 5593 bits: 4 opportunities data, 5 stuff.
// - Deficit backlog gives 5591 bits: 2 opportunities data, 7 stuff.
// - Backlog carries over, so a slow drift yields occasional extra bits.
// - Each of nine rows has one opportunity, used for data from row 0 upward.
// - Five control bits per row: zeros for data, ones for stuff.
module dssm_mapper #(
	parameter int ENV_CYCLES = dssm_pkg::ENV_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ds3_valid,
	input wire logic i_env_ready,
	output logic o_env_valid,
	output logic [dssm_pkg::CNT_W-1:0] o_env_bits,
	output logic [dssm_pkg::ROWS-1:0] o_env_data_rows,
	output logic [dssm_pkg::CTRL_W-1:0] o_env_ctrl,
	output logic o_env_overrun,
	input wire logic i_rx_valid,
	input wire logic [dssm_pkg::CTRL_W-1:0] i_rx_ctrl,
	output logic o_rx_valid,
	output logic [dssm_pkg::ROWS-1:0] o_rx_data_rows,
	output logic [dssm_pkg::CNT_W-1:0] o_rx_bits
);
	import dssm_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [3:0] count_rows(input logic [ROWS-1:0] m);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < ROWS; k++) begin
			n = n + {3'h0, m[k]};
		end
		return n;
	endfunction

	function automatic logic vote5(input logic [CTRL_PER_ROW-1:0] b);
		logic [2:0] n;
		n = 3'h0;
		for (int k = 0; k < CTRL_PER_ROW; k++) begin
			n = n + {2'h0, b[k]};
		end
		return n >= VOTE_MIN;
	endfunction

	// ****************************************
	// Envelope timer
	// ****************************************
	logic [15:0] env_cnt_r;
	logic env_tick;
	logic pend_r;
	logic push;
	logic in_ready;

	assign env_tick = (env_cnt_r == 16'(ENV_CYCLES - 1));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			env_cnt_r <= 16'h0000;
		end else if (env_tick) begin
			env_cnt_r <= 16'h0000;
		end else begin
			env_cnt_r <= env_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pend_r <= 1'b0;
		end else if (env_tick) begin
			pend_r <= 1'b1;
		end else if (push) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_env_overrun <= 1'b0;
		end else begin
			o_env_overrun <= env_tick && pend_r && !push;
		end
	end

	assign push = pend_r && in_ready;

	// ****************************************
	// Arrival count and backlog
	// ****************************************
	logic [ACC_W-1:0] arr_r;
	logic signed [BL_W-1:0] backlog_r;
	logic signed [BL_W-1:0] total;
	logic [CNT_W-1:0] take;
	logic [3:0] opp;
	logic [ROWS-1:0] data_rows;
	logic [CTRL_W-1:0] ctrl;

	assign total = backlog_r + $signed({2'b00, arr_r});

	always_comb begin
		if (total > $signed({3'b000, NOM_BITS})) begin
			take = FAST_BITS;
			opp = FAST_OPP;
		end else if (total < $signed({3'b000, NOM_BITS})) begin
			take = SLOW_BITS;
			opp = SLOW_OPP;
		end else begin
			take = NOM_BITS;
			opp = NOM_OPP;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			arr_r <= '0;
		end else if (push) begin
			arr_r <= {{(ACC_W-1){1'b0}}, i_ds3_valid};
		end else begin
			arr_r <= arr_r + {{(ACC_W-1){1'b0}}, i_ds3_valid};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			backlog_r <= '0;
		end else if (push) begin
			backlog_r <= total - $signed({3'b000, take});
		end
	end

	// ****************************************
	// Per-row opportunity use and control bits
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < ROWS; g++) begin : g_row
			assign data_rows[g] = (4'(g) < opp);
			assign ctrl[g*CTRL_PER_ROW +: CTRL_PER_ROW] = {CTRL_PER_ROW{!data_rows[g]}};
			a_row_ctrl_code: assert property (@(posedge i_clk) disable iff (i_rst)
				o_env_valid |-> (o_env_ctrl[g*CTRL_PER_ROW +: CTRL_PER_ROW]
				== (o_env_data_rows[g] ? 5'h00 : 5'h1F)))
				else $error("row control bits disagree with row use");
		end
	endgenerate

	// ****************************************
	// Two-entry output buffer
	// ****************************************
	logic [WORD_W-1:0] in_word;
	logic [WORD_W-1:0] skid_r;
	logic skid_v_r;
	logic out_free;

	assign in_word = {take, data_rows, ctrl};
	assign in_ready = !skid_v_r;
	assign out_free = !o_env_valid || i_env_ready;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_env_valid <= 1'b0;
			o_env_bits <= '0;
			o_env_data_rows <= '0;
			o_env_ctrl <= '0;
		end else if (out_free) begin
			if (skid_v_r) begin
				{o_env_bits, o_env_data_rows, o_env_ctrl} <= skid_r;
				o_env_valid <= 1'b1;
			end else if (push) begin
				{o_env_bits, o_env_data_rows, o_env_ctrl} <= in_word;
				o_env_valid <= 1'b1;
			end else begin
				o_env_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			skid_r <= '0;
			skid_v_r <= 1'b0;
		end else if (out_free) begin
			skid_v_r <= 1'b0;
		end else if (push) begin
			skid_r <= in_word;
			skid_v_r <= 1'b1;
		end
	end

	// ****************************************
	// Far-end control decode
	// ****************************************
	logic [ROWS-1:0] rx_rows;
	generate
		for (g = 0; g < ROWS; g++) begin : g_vote
			assign rx_rows[g] = !vote5(i_rx_ctrl[g*CTRL_PER_ROW +: CTRL_PER_ROW]);
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rx_valid <= 1'b0;
			o_rx_data_rows <= '0;
			o_rx_bits <= '0;
		end else begin
			o_rx_valid <= i_rx_valid;
			if (i_rx_valid) begin
				o_rx_data_rows <= rx_rows;
				o_rx_bits <= FIXED_BITS + {9'h000, count_rows(rx_rows)};
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_env_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
		env_tick |=> (env_cnt_r == 16'h0000) ##1 (!env_tick)[*8])
		else $error("envelope tick spacing wrong");
	a_nominal_take: assert property (@(posedge i_clk) disable iff (i_rst)
		(push && total == $signed({3'b000, NOM_BITS})) |=> skid_v_r || o_env_bits == NOM_BITS)
		else $error("nominal envelope not 5592 bits");
	a_fixed_plus_opp: assert property (@(posedge i_clk) disable iff (i_rst)
		o_env_valid |-> (o_env_bits == FIXED_BITS + {9'h000, count_rows(o_env_data_rows)}))
		else $error("bit count not fixed plus opportunities");
	a_nominal_rows: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_env_valid && o_env_bits == NOM_BITS) |-> count_rows(o_env_data_rows) == NOM_OPP)
		else $error("nominal envelope opportunity use wrong");
	a_negative_stuff: assert property (@(posedge i_clk) disable iff (i_rst)
		(push && total > $signed({3'b000, NOM_BITS})) |-> take == FAST_BITS && opp == FAST_OPP)
		else $error("surplus did not negative stuff");
	a_positive_stuff: assert property (@(posedge i_clk) disable iff (i_rst)
		(push && total < $signed({3'b000, NOM_BITS})) |-> take == SLOW_BITS && opp == SLOW_OPP)
		else $error("deficit did not positive stuff");
	a_backlog_kept: assert property (@(posedge i_clk) disable iff (i_rst)
		push |=> backlog_r == $past(total) - $signed({3'b000, $past(take)}))
		else $error("backlog lost data bits");
	a_backlog_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		(backlog_r < $signed(BL_LIMIT)) && (backlog_r > -$signed(BL_LIMIT)))
		else $error("backlog drifted out of bound");
	a_rx_vote: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx_valid && i_rx_ctrl[4:0] == 5'h01) |=> o_rx_data_rows[0])
		else $error("single control bit error not tolerated");
	a_rx_count: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx_valid && i_rx_ctrl == '1) |=> o_rx_valid && o_rx_bits == FIXED_BITS)
		else $error("far-end count wrong");
endmodule // dssm_mapper

// [dv/dssm_far_end.sv]
// Far-end consumer and demap feed model
`timescale 1ns/1ps
module dssm_far_end (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_stall,
	input wire logic [dssm_pkg::CTRL_W-1:0] i_err,
	input wire logic i_env_valid,
	input wire logic [dssm_pkg::CTRL_W-1:0] i_env_ctrl,
	output logic o_env_ready,
	output logic o_rx_valid,
	output logic [dssm_pkg::CTRL_W-1:0] o_rx_ctrl
);
	import dssm_pkg::*;
	// ****************************************
	// Consumer, not ready while stalled
	// ****************************************
	always_ff @(posedge i_clk) begin
		o_env_ready <= !i_rst && !i_stall;
	end
	// ****************************************
	// Accepted control vector to demap side
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rx_valid <= 1'b0;
			o_rx_ctrl <= '0;
		end else begin
			o_rx_valid <= i_env_valid && o_env_ready;
			if (i_env_valid && o_env_ready) begin
				o_rx_ctrl <= i_env_ctrl ^ i_err;
			end else begin
				o_rx_ctrl <= ~o_rx_ctrl;
			end
		end
	end
endmodule // dssm_far_end

// [dv/testbench.sv]
// Self-checking bench for the stuff mapper
`timescale 1ns/1ps
module testbench;
	import dssm_pkg::*;
	localparam int ENV = ENV_CYC;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ds3_valid = 1'b0;
	logic stall = 1'b0;
	logic [CTRL_W-1:0] err = '0;
	logic env_ready, o_env_valid, o_env_overrun, rx_in_valid, o_rx_valid;
	logic [CNT_W-1:0] o_env_bits, o_rx_bits;
	logic [ROWS-1:0] o_env_data_rows, o_rx_data_rows;
	logic [CTRL_W-1:0] o_env_ctrl, rx_ctrl;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int t_last = 0;
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	dssm_mapper #(.ENV_CYCLES(ENV)) dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_ds3_valid(i_ds3_valid), .i_env_ready(env_ready), .o_env_valid(o_env_valid),
		.o_env_bits(o_env_bits), .o_env_data_rows(o_env_data_rows), .o_env_ctrl(o_env_ctrl),
		.o_env_overrun(o_env_overrun), .i_rx_valid(rx_in_valid), .i_rx_ctrl(rx_ctrl),
		.o_rx_valid(o_rx_valid), .o_rx_data_rows(o_rx_data_rows), .o_rx_bits(o_rx_bits));
	dssm_far_end far (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall), .i_err(err),
		.i_env_valid(o_env_valid), .i_env_ctrl(o_env_ctrl), .o_env_ready(env_ready),
		.o_rx_valid(rx_in_valid), .o_rx_ctrl(rx_ctrl));
	// ****************************************
	// Reporting
	// ****************************************
	task results;
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task wait_for(input int lim, input logic sel);
		int k;
		k = 0;
		do begin
			@(posedge i_clk);
			#1;
			k++;
			if (k > lim) begin
				check(1'b0, "wait bound used up");
				results();
			end
		end while (sel ? !o_rx_valid : !(o_env_valid && env_ready));
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task run_env(input int n, input logic [3:0] opp, input logic first);
		logic [CTRL_W-1:0] ec;
		logic [ROWS-1:0] er;
		int k;
		for (k = 0; k < ROWS; k++) begin
			er[k] = (k < opp);
			ec[5*k +: 5] = (k < opp) ? 5'h00 : 5'h1F;
		end
		for (k = 0; k < n; k++) begin
			@(posedge i_clk);
			i_ds3_valid <= 1'b1;
		end
		@(posedge i_clk);
		i_ds3_valid <= 1'b0;
		wait_for(ENV, 1'b0);
		check(o_env_bits === n[CNT_W-1:0], "envelope bit count");
		check(o_env_bits === FIXED_BITS + CNT_W'(opp), "fixed plus used");
		check(o_env_data_rows === er, "rows used for data");
		check(o_env_ctrl === ec, "control bits per row");
		if (!first) begin
			check(cyc - t_last == ENV, "envelope spacing");
		end
		t_last = cyc;
		wait_for(8, 1'b1);
		check(o_rx_data_rows === er, "voted rows");
		check(o_rx_bits === FIXED_BITS + CNT_W'(opp), "demapped count");
	endtask
	task stall_env;
		int k;
		int ov;
		int rx;
		ov = 0;
		rx = 0;
		@(posedge i_clk);
		stall <= 1'b1;
		// Nominal arrivals for three envelopes, then none, so the merged one stays nominal
		for (k = 0; k < 4 * ENV + 10; k++) begin
			@(posedge i_clk);
			i_ds3_valid <= (k < 3 * ENV) && (k % ENV < NOM_BITS);
			#1;
			ov += o_env_overrun === 1'b1;
		end
		check(ov > 0, "no overrun while stalled");
		check(o_env_valid === 1'b1, "descriptor dropped while stalled");
		@(posedge i_clk);
		stall <= 1'b0;
		// Flip data rows to all ones so every row reads as stuff
		err <= {{(CTRL_W-15){1'b0}}, 15'h7FFF};
		ov = 0;
		for (k = 0; k < 12; k++) begin
			@(posedge i_clk);
			#1;
			ov += o_env_valid === 1'b1 && env_ready === 1'b1;
			if (o_rx_valid === 1'b1) begin
				rx++;
				check(o_rx_bits === FIXED_BITS && o_rx_data_rows === '0, "all-stuff vote");
			end
		end
		check(ov >= 2, "buffered descriptors lost");
		check(rx > 0, "no envelope demapped after stall");
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		run_env(NOM_BITS, NOM_OPP, 1'b1);
		@(posedge i_clk);
		err <= {ROWS{5'h01}};
		run_env(FAST_BITS, FAST_OPP, 1'b0);
		run_env(SLOW_BITS, SLOW_OPP, 1'b0);
		@(posedge i_clk);
		err <= {ROWS{5'h10}};
		run_env(NOM_BITS, NOM_OPP, 1'b0);
		stall_env();
		results();
	end
endmodule // testbench
